/* File: rtl/ipd_pkg.sv */
// package: constants, types and register map of the interrupt priority dispatch block
`default_nettype none
package ipd_pkg;
   localparam int NUM_SRC = 7;
   localparam int SRC_W = 3;
   // fixed order position of the first source in the table (conversion done)
   localparam int FIRST_ORDER = 15;
   localparam logic [15:0] VEC_BASE = 16'h007B;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   // source positions inside the 7-bit flag and enable groups
   localparam int SRC_CONV = 0;
   localparam int SRC_SOFT0 = 1;
   localparam int SRC_UNUSED = 5;
   localparam int SRC_XTAL = 6;
   // bit positions in the documented core registers
   localparam int CONV_FLAG_BIT = 5;
   localparam int SOFT_FLAG_LSB = 4;
   localparam int XTAL_FLAG_BIT = 7;
   localparam int ENABLE_LSB = 1;
   // timing figures in system clocks
   localparam int DETECT_CLKS = 1;
   localparam int CALL_CLKS = 4;
   localparam logic [2:0] CALL_CNT = 3'(CALL_CLKS);
   // register word offsets (byte addresses)
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_PRIO = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [6:0] PRIO_RESET = 7'h00;
   localparam logic [6:0] EN_RESET = 7'h00;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam int EV_DISPATCH = 0;
   localparam int EV_PREEMPT = 1;
   typedef enum logic [1:0] {IPD_LVL_NONE, IPD_LVL_LOW, IPD_LVL_HIGH} ipd_level_t;
   typedef struct packed {
      logic valid;
      logic high;
      logic [2:0] src;
   } ipd_pick_t;
   typedef struct packed {
      logic fetch;
      logic reti;
      logic stall;
   } ipd_core_t;
endpackage
`default_nettype wire

/* File: rtl/ipd_level_pick.sv */
// lowest-index picker among the requests of one priority level
`default_nettype none
module ipd_level_pick
   import ipd_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   // requests already qualified for this level
   input wire logic [N-1:0] req,
   input wire logic high,
   // result
   output var ipd_pick_t pick
);
   always_comb begin
      pick = '0;
      pick.high = high;
      // [R6] fixed order, lower number wins
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            pick.valid = 1'b1;
            pick.src = 3'(i);
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/ipd_wb_regs.sv */
// wishbone register file: enables, priorities, event status and mask
`default_nettype none
module ipd_wb_regs
   import ipd_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // block state
   input wire logic [6:0] flags,
   input wire logic [7:0] coreStatus,
   input wire logic [1:0] events,
   output logic [6:0] enable,
   output logic [6:0] prio,
   output logic irq
);
   logic [6:0] enable_reg, enable_next, prio_reg, prio_next;
   logic [1:0] stat_reg, stat_next, mask_reg, mask_next;
   logic ack_reg, ack_next, irq_reg, irq_next;
   logic [31:0] dat_reg, dat_next;
   logic wr;
   always_comb begin
      // a write lands at the edge where the master samples ack
      wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
      enable_next = enable_reg;
      prio_next = prio_reg;
      mask_next = mask_reg;
      stat_next = stat_reg;
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      dat_next = '0;
      if (wr && wb_adr_i == ADDR_ENABLE) begin
         enable_next = wb_dat_i[6:0];
      end
      if (wr && wb_adr_i == ADDR_PRIO) begin
         prio_next = wb_dat_i[6:0];
      end
      if (wr && wb_adr_i == ADDR_IRQ_MASK) begin
         mask_next = wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == ADDR_IRQ_STAT) begin
         stat_next = stat_reg & ~wb_dat_i[1:0];
      end
      // set wins over a write-one clear in the same cycle
      stat_next = stat_next | events;
      case (wb_adr_i)
         ADDR_FLAGS: dat_next = {25'h0000000, flags};
         ADDR_ENABLE: dat_next = {25'h0000000, enable_reg};
         ADDR_PRIO: dat_next = {25'h0000000, prio_reg};
         ADDR_STATUS: dat_next = {24'h000000, coreStatus};
         ADDR_IRQ_STAT: dat_next = {30'h00000000, stat_reg};
         ADDR_IRQ_MASK: dat_next = {30'h00000000, mask_reg};
         default: dat_next = '0;
      endcase
      irq_next = |(stat_next & mask_next);
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // [R4] all sources start at low level
         prio_reg <= PRIO_RESET;
         enable_reg <= EN_RESET;
         mask_reg <= MASK_RESET;
         stat_reg <= 2'h0;
         ack_reg <= 1'b0;
         dat_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         prio_reg <= prio_next;
         enable_reg <= enable_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         irq_reg <= irq_next;
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign enable = enable_reg;
   assign prio = prio_reg;
   assign irq = irq_reg;
endmodule
`default_nettype wire

/* File: rtl/ipd_dispatch.sv */
// interrupt priority resolution and vector dispatch toward the processor core
// Behaviour
// [R1] each source has its own priority bit
// [R2] high request preempts running low routine
// [R3] nothing dispatches inside a high routine
// [R4] priority bits reset to low
// [R5] high level wins over low level
// [R6] equal level: fixed source order wins
// [R7] conversion and software vectors fixed
// [R8] crystal vector fixed, slot unused
// [R9] flags sampled and decoded every clock
// [R10] one detect clock, four call clocks
// [R11] one instruction after return before call
// [R12] worst case eighteen clocks via return
// [R13] no dispatch while flash operation stalls
// [R14] equal or lower waits for return
// [R15] dispatch needs both flag and enable
//
// Added by the designer: the Wishbone slave port and the register addresses.
`default_nettype none
module ipd_dispatch
   import ipd_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pending flag sources
   input wire logic [7:0] converterControl,
   input wire logic [7:0] softIrqFlags,
   input wire logic [7:0] extOscControl,
   // processor core handshake
   input wire ipd_core_t core,
   output logic callReq,
   output logic [15:0] callVector,
   output logic [2:0] callSrc,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // interrupt to the system
   output logic irq
);
   typedef enum logic [1:0] {IPD_IDLE, IPD_CALL, IPD_HOLD} ipd_state_t;
   logic [6:0] flags, enable, prio, req, reqHigh, reqLow;
   logic [7:0] coreStatus;
   logic [1:0] events;
   ipd_pick_t pickHigh, pickLow, sel;
   ipd_state_t state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next, src_reg, src_next;
   logic [1:0] depth_reg, depth_next;
   logic inHigh_reg, inHigh_next, inLow_reg, inLow_next;
   logic hold_reg, hold_next;
   logic sample_reg, sample_next;
   ipd_pick_t det_reg, det_next;
   logic callReq_reg, callReq_next;
   logic [15:0] vec_reg, vec_next;
   logic allow;
   localparam int CALL_LAT = DETECT_CLKS + CALL_CLKS;

   // [R7] [R8] flag gathering from the core registers
   assign flags = {extOscControl[XTAL_FLAG_BIT], 1'b0,
                   softIrqFlags[SOFT_FLAG_LSB +: 4], converterControl[CONV_FLAG_BIT]};
   // [R15] only enabled flags request
   assign req = flags & enable & ~(7'(1) << SRC_UNUSED);
   // [R1] split requests by the per-source level bit
   assign reqHigh = req & prio;
   assign reqLow = req & ~prio;

   ipd_level_pick #(.N(NUM_SRC)) u_pick_high (
      .req(reqHigh),
      .high(1'b1),
      .pick(pickHigh)
   );
   ipd_level_pick #(.N(NUM_SRC)) u_pick_low (
      .req(reqLow),
      .high(1'b0),
      .pick(pickLow)
   );

   always_comb begin
      // [R5] high level first
      sel = pickHigh.valid ? pickHigh : pickLow;
      // [R2] [R3] [R14] admission by running level
      allow = 1'b0;
      if (!inHigh_reg) begin
         allow = inLow_reg ? pickHigh.valid : sel.valid;
      end
      if (inLow_reg && !inHigh_reg) begin
         sel = pickHigh;
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      src_next = src_reg;
      depth_next = depth_reg;
      inHigh_next = inHigh_reg;
      inLow_next = inLow_reg;
      hold_next = hold_reg;
      callReq_next = 1'b0;
      vec_next = vec_reg;
      // [R9] decode sampled every clock
      sample_next = 1'b1;
      det_next = '0;
      // [R11] [R14] after a return one instruction must complete
      if (core.reti) begin
         hold_next = 1'b1;
         if (inHigh_reg) begin
            inHigh_next = 1'b0;
         end else begin
            inLow_next = 1'b0;
         end
      end else if (core.fetch) begin
         // [R12] the fetch ends the wait
         hold_next = 1'b0;
      end
      case (state_reg)
         IPD_IDLE: begin
            // [R13] no dispatch during a flash stall
            if (allow && !hold_reg && !core.reti && !core.stall && sample_reg) begin
               det_next = sel;
               state_next = IPD_CALL;
               cnt_next = CALL_CNT;
            end
         end
         IPD_CALL: begin
            // [R10] four clocks to complete the call
            if (cnt_reg == 3'(DETECT_CLKS)) begin
               callReq_next = 1'b1;
               src_next = det_reg.src;
               // [R7] [R8] vector from source slot
               vec_next = VEC_BASE + 16'(VEC_STEP * 16'(det_reg.src));
               if (det_reg.high) begin
                  inHigh_next = 1'b1;
               end else begin
                  inLow_next = 1'b1;
               end
               state_next = IPD_IDLE;
            end else begin
               cnt_next = cnt_reg - 3'(1);
            end
            det_next = det_reg;
         end
         default: state_next = IPD_IDLE;
      endcase
      depth_next = {inHigh_next, inLow_next};
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= IPD_IDLE;
         cnt_reg <= 3'h0;
         src_reg <= 3'h0;
         depth_reg <= 2'h0;
         inHigh_reg <= 1'b0;
         inLow_reg <= 1'b0;
         hold_reg <= 1'b0;
         sample_reg <= 1'b0;
         det_reg <= '0;
         callReq_reg <= 1'b0;
         vec_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         src_reg <= src_next;
         depth_reg <= depth_next;
         inHigh_reg <= inHigh_next;
         inLow_reg <= inLow_next;
         hold_reg <= hold_next;
         sample_reg <= sample_next;
         det_reg <= det_next;
         callReq_reg <= callReq_next;
         vec_reg <= vec_next;
      end
   end

   assign events[EV_DISPATCH] = callReq_next;
   assign events[EV_PREEMPT] = callReq_next && det_reg.high && inLow_reg;
   assign coreStatus = {1'b0, hold_reg, depth_reg, 1'b0, src_reg};

   ipd_wb_regs u_regs (
      .clk_sys(clk_sys),
      .reset(reset),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .flags(flags),
      .coreStatus(coreStatus),
      .events(events),
      .enable(enable),
      .prio(prio),
      .irq(irq)
   );

   assign callReq = callReq_reg;
   assign callVector = vec_reg;
   assign callSrc = src_reg;

   // assertions
   // [R10] detect plus call clocks
   a_call_latency: assert property (@(posedge clk_sys) disable iff (reset) // [R10]
      (state_reg == IPD_IDLE && state_next == IPD_CALL)
      |-> ##CALL_LAT callReq_reg)
      else $error("call not issued five clocks after detect");

   // [R10] call is one pulse
   a_call_pulse: assert property (@(posedge clk_sys) disable iff (reset) // [R10]
      callReq_reg
      |=> !callReq_reg)
      else $error("call request longer than one cycle");

   // [R3] high routine blocks all
   a_high_blocks: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
      (inHigh_reg && !core.reti)
      |-> state_next != IPD_CALL || state_reg != IPD_IDLE)
      else $error("dispatch inside high routine");

   // [R14] equal level waits
   a_low_waits: assert property (@(posedge clk_sys) disable iff (reset) // [R14]
      (inLow_reg && !pickHigh.valid && state_reg == IPD_IDLE)
      |=> state_reg != IPD_CALL)
      else $error("equal level request preempted low routine");

   // [R2] high preempts low routine
   a_high_preempts: assert property (@(posedge clk_sys) disable iff (reset) // [R2]
      (state_reg == IPD_IDLE && inLow_reg && !inHigh_reg && pickHigh.valid && !hold_reg && !core.reti && !core.stall)
      |=> state_reg == IPD_CALL)
      else $error("high request did not preempt low routine");

   // [R5] high level first
   a_high_first: assert property (@(posedge clk_sys) disable iff (reset) // [R5]
      (state_reg == IPD_IDLE && state_next == IPD_CALL && pickHigh.valid)
      |=> det_reg.high)
      else $error("low chosen over high");

   // [R6] no lower index waiting
   a_same_level: assert property (@(posedge clk_sys) disable iff (reset) // [R6]
      (state_reg == IPD_IDLE && state_next == IPD_CALL)
      |-> ((sel.high ? reqHigh : reqLow) & ((7'(1) << sel.src) - 7'(1))) == 7'h00)
      else $error("fixed order not kept within a level");

   // [R1] level follows its bit
   a_level_bit: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
      (state_reg == IPD_IDLE && state_next == IPD_CALL)
      |-> sel.high == prio[sel.src])
      else $error("level does not match the priority bit");

   // [R4] priorities low after reset
   a_prio_reset: assert property (@(posedge clk_sys) // [R4]
      (!reset && $past(reset))
      |-> prio == PRIO_RESET)
      else $error("priority bits not low after reset");

   // [R13] stall blocks dispatch
   a_stall_holds: assert property (@(posedge clk_sys) disable iff (reset) // [R13]
      core.stall
      |=> state_reg != IPD_CALL || $past(state_reg) != IPD_IDLE)
      else $error("dispatch during flash stall");

   // [R11] no call at return
   a_reti_gap: assert property (@(posedge clk_sys) disable iff (reset) // [R11]
      core.reti
      |=> state_reg == IPD_IDLE || $past(state_reg) == IPD_CALL)
      else $error("call started right after return");

   // [R12] wait for the fetch
   a_hold_return: assert property (@(posedge clk_sys) disable iff (reset) // [R12]
      hold_reg
      |=> state_reg != IPD_CALL || $past(state_reg) != IPD_IDLE)
      else $error("call started before the instruction after return");

   // [R15] flag and enable needed
   a_enabled_only: assert property (@(posedge clk_sys) disable iff (reset) // [R15]
      (state_reg == IPD_IDLE && state_next == IPD_CALL)
      |-> enable[sel.src] && flags[sel.src])
      else $error("disabled source dispatched");

   // [R7] vector from the slot
   a_vector_map: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
      callReq_reg
      |-> callVector == VEC_BASE + 16'(VEC_STEP * 16'(callSrc)))
      else $error("wrong vector");

   // [R7] vector held between calls
   a_vector_hold: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
      !callReq_next
      |=> $stable(callVector))
      else $error("vector changed without a call");

   // [R8] unused slot never called
   a_unused_slot: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
      callReq_reg
      |-> callSrc != 3'(SRC_UNUSED))
      else $error("unused slot dispatched");
endmodule
`default_nettype wire

/* File: testbench/ipd_core_model.sv */
// processor core model: instruction boundaries, returns and flash stalls
`default_nettype none
module ipd_core_model
   import ipd_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // commands from the bench
   input wire logic retiCmd,
   input wire logic stallCmd,
   input wire logic [3:0] pace,
   // dispatch side
   input wire logic callReq,
   output var ipd_core_t core
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   // boundaries, returns, stalls
   // pace 8 stands for the slowest instruction after a return
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt <= 4'h0;
         core <= '0;
      end else begin
         core.reti <= retiCmd;
         core.stall <= stallCmd;
         core.fetch <= !stallCmd && !retiCmd && cnt == pace - 4'h1;
         if (retiCmd || callReq || stallCmd || cnt == pace - 4'h1) begin
            cnt <= 4'h0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/interrupt_priority_dispatch_test.sv */
// self-checking bench: register access and dispatch sequences
`default_nettype none
module interrupt_priority_dispatch_test
   import ipd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic [7:0] convCtl = 8'h00, softFlags = 8'h00, oscCtl = 8'h00, wbAdr = 8'h00;
   logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0, retiCmd = 1'h0, stallCmd = 1'h0;
   logic [3:0] wbSel = 4'hF, pace = 4'h2;
   logic [31:0] wbDatW = 32'h0, wbDatR, rd;
   logic wbAck, callReq, irq;
   logic [15:0] callVector;
   logic [2:0] callSrc;
   ipd_core_t core;
   int n_errors = 0, n_compared = 0, cycles = 0, n;
   int order[6] = '{6, 0, 1, 2, 3, 4};
   logic [7:0] regs[7] = '{ADDR_FLAGS, ADDR_ENABLE, ADDR_PRIO, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h1C};
   always #10 clk_sys = ~clk_sys;
   ipd_dispatch dut (.clk_sys(clk_sys), .reset(reset), .converterControl(convCtl), .softIrqFlags(softFlags),
      .extOscControl(oscCtl), .core(core), .callReq(callReq), .callVector(callVector), .callSrc(callSrc),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .irq(irq));
   ipd_core_model model (.clk_sys(clk_sys), .reset(reset), .retiCmd(retiCmd), .stallCmd(stallCmd),
      .pace(pace), .callReq(callReq), .core(core));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cmpCnt(input int got, input int lo, input int hi, input string what);
      n_compared++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("[FAIL] %0t %s count %0d", $time, what, got);
      end
   endtask
   // one classic cycle; the request stands until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      do begin
         @(posedge clk_sys);
         k++;
      end while (wbAck !== 1'h1 && k < 20);
      rd = wbDatR;
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      cmpCnt(k, 1, 19, "ack wait");
   endtask
   task automatic flags(input logic [6:0] f);
      @(posedge clk_sys);
      convCtl <= {2'h0, f[0], 5'h00};
      softFlags <= {f[4:1], 4'h0};
      oscCtl <= {f[6], 7'h00};
   endtask
   task automatic quiet(input int k);
      repeat (k) begin
         @(posedge clk_sys);
         cmpVal(callReq, 32'h0, "unexpected call");
      end
   endtask
   task automatic expCall(input int src, input int lim);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (callReq !== 1'h1 && n < lim);
      cmpVal(callReq, 32'h1, "call");
      cmpVal(callSrc, src, "source");
      cmpVal(callVector, src == SRC_XTAL ? 32'h00AB : VEC_BASE + VEC_STEP * src, "vector");
      @(posedge clk_sys);
      cmpVal(callReq, 32'h0, "pulse width");
   endtask
   task automatic reti();
      @(posedge clk_sys);
      retiCmd <= 1'h1;
      @(posedge clk_sys);
      retiCmd <= 1'h0;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      logic [6:0] f;
      int m;
      repeat (8) @(posedge clk_sys);
      reset <= 1'h0;
      wb(1'h1, ADDR_FLAGS, 32'h7F);
      wb(1'h1, 8'h1C, 32'hFF);
      foreach (regs[i]) begin
         wb(1'h0, regs[i], 32'h0);
         cmpVal(rd, 32'h0, "reset value");
      end
      wb(1'h1, ADDR_PRIO, 32'h55);
      wb(1'h0, ADDR_PRIO, 32'h0);
      cmpVal(rd, 32'h55, "priority bits");
      // a write without the low byte lane is ignored
      wbSel <= 4'hE;
      wb(1'h1, ADDR_PRIO, 32'h0);
      wbSel <= 4'hF;
      wb(1'h0, ADDR_PRIO, 32'h0);
      cmpVal(rd, 32'h55, "lane refused");
      wb(1'h1, ADDR_PRIO, 32'h0);
      flags(7'h01);
      quiet(12);
      wb(1'h0, ADDR_FLAGS, 32'h0);
      cmpVal(rd, 32'h1, "flag view");
      flags(7'h00);
      wb(1'h1, ADDR_ENABLE, 32'h5F);
      wb(1'h0, ADDR_ENABLE, 32'h0);
      cmpVal(rd, 32'h5F, "enables");
      $display("done: registers");
      // five edges to the call, one more to sample the registered pulse
      flags(7'h01);
      expCall(0, 12);
      cmpCnt(n, DETECT_CLKS + CALL_CLKS + 1, DETECT_CLKS + CALL_CLKS + 1, "latency");
      flags(7'h00);
      cmpVal(irq, 32'h0, "masked irq");
      wb(1'h1, ADDR_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk_sys);
      cmpVal(irq, 32'h1, "irq raised");
      wb(1'h1, ADDR_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk_sys);
      cmpVal(irq, 32'h0, "irq cleared");
      reti();
      // let the fetch after the return pass, so only the stall can block
      repeat (4) @(posedge clk_sys);
      stallCmd <= 1'h1;
      flags(7'h01);
      quiet(12);
      stallCmd <= 1'h0;
      expCall(0, 12);
      flags(7'h00);
      reti();
      $display("done: latency and stall");
      wb(1'h1, ADDR_PRIO, 32'h40);
      f = 7'h5F;
      flags(f);
      foreach (order[i]) begin
         expCall(order[i], 20);
         f[order[i]] = 1'h0;
         flags(f);
         quiet(8);
         reti();
      end
      $display("done: order");
      wb(1'h1, ADDR_IRQ_STAT, 32'h3);
      wb(1'h1, ADDR_IRQ_MASK, 32'h2);
      wb(1'h1, ADDR_PRIO, 32'h42);
      flags(7'h01);
      expCall(0, 12);
      flags(7'h40);
      expCall(6, 12);
      flags(7'h02);
      quiet(10);
      reti();
      expCall(1, 20);
      flags(7'h00);
      wb(1'h0, ADDR_IRQ_STAT, 32'h0);
      cmpVal(rd, 32'h3, "events");
      cmpVal(irq, 32'h1, "preempt irq");
      reti();
      reti();
      $display("done: preemption");
      wb(1'h1, ADDR_IRQ_STAT, 32'h3);
      pace <= 4'h8;
      flags(7'h01);
      expCall(0, 12);
      flags(7'h04);
      quiet(10);
      reti();
      m = 0;
      do begin
         @(posedge clk_sys);
         m++;
         cmpVal(callReq, 32'h0, "call before fetch");
      end while (core.fetch !== 1'h1 && m < 20);
      expCall(2, 8);
      cmpCnt(n, 1, CALL_CLKS + 2, "call after fetch");
      cmpCnt(m + n, 1, 18, "worst case");
      flags(7'h00);
      reti();
      $display("done: return path");
      conclude();
   end
endmodule
`default_nettype wire
